// *** tb/occm_channel_tb.sv ***
/* Bench for the channel 2 output-compare block: mode table, buffering, fast trigger, polarity.
   Assumes occm_channel with CNT_W of 16 and occm_consts.vh on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "occm_consts.vh"
module occm_channel_tb;
    localparam logic [7:0] A_MODE = `OCCM_OFS_MODE_CFG;
    localparam logic [7:0] A_CMP  = `OCCM_OFS_COMPARE;
    localparam logic [7:0] A_CTL  = `OCCM_OFS_CONTROL;
    typedef struct packed {logic init; logic [2:0] mode; logic [15:0] a; logic [15:0] b; logic down; logic exp;} occm_row_t;
    logic        clk_sys = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic [15:0] counter_value = 16'h0000;
    logic        count_down = 1'b0;
    logic        trigger_in = 1'b0;
    logic        update_event_in = 1'b0;
    logic        counter_reinit;
    logic        single_pulse_flag;
    logic        ch2_reference_level;
    logic        ch2_output_pin;
    int          mismatches = 0;
    int          n_compared = 0;
    int          cycles = 0;
    occm_row_t   rows [11];
    always #20 clk_sys = ~clk_sys;
    occm_channel #(.CNT_W(16)) occm_channel_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .counter_value(counter_value), .count_down(count_down), .trigger_in(trigger_in),
        .update_event_in(update_event_in), .counter_reinit(counter_reinit), .single_pulse_flag(single_pulse_flag),
        .ch2_reference_level(ch2_reference_level), .ch2_output_pin(ch2_output_pin));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            final_report;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    task automatic lvl(input logic exp);
        #1 chk("ch2_reference_level", {31'h0, exp}, {31'h0, ch2_reference_level});
    endtask
    function automatic logic [31:0] cfg(input logic [2:0] m, input logic b, input logic f, input logic [1:0] d);
        return {17'h0, m, b, f, d, 8'h00};
    endfunction
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 chk("reg_rdata", exp, reg_rdata);
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        rows = '{'{1'b0, 3'h1, 16'h3, 16'h5, 1'b0, 1'b1}, '{1'b1, 3'h2, 16'h3, 16'h5, 1'b0, 1'b0},
                 '{1'b0, 3'h3, 16'h3, 16'h5, 1'b0, 1'b1}, '{1'b1, 3'h3, 16'h3, 16'h5, 1'b0, 1'b0},
                 '{1'b1, 3'h0, 16'h3, 16'h5, 1'b0, 1'b1}, '{1'b1, 3'h4, 16'h3, 16'h5, 1'b0, 1'b0},
                 '{1'b0, 3'h5, 16'h3, 16'h5, 1'b0, 1'b1}, '{1'b0, 3'h6, 16'h5, 16'h3, 1'b0, 1'b1},
                 '{1'b1, 3'h6, 16'h3, 16'h6, 1'b1, 1'b0}, '{1'b0, 3'h7, 16'h3, 16'h7, 1'b1, 1'b1},
                 '{1'b0, 3'h6, 16'h3, 16'h4, 1'b0, 1'b0}};
        cyc(4);
        rst_n <= 1'b1;
        for (int i = 0; i < 6; i++) rd(8'(i * 4), 32'h0000_0000);
        wr(A_CMP, 32'h0000_0005);
        foreach (rows[i]) begin
            @(posedge clk_sys);
            counter_value <= rows[i].a;
            count_down <= rows[i].down;
            wr(A_MODE, cfg({2'h2, rows[i].init}, 1'b0, 1'b0, 2'h0));
            cyc(2);
            wr(A_MODE, cfg(rows[i].mode, 1'b0, 1'b0, 2'h0));
            cyc(2);
            counter_value <= rows[i].b;
            cyc(2);
            lvl(rows[i].exp);
        end
        @(posedge clk_sys);
        counter_value <= 16'h0008;
        count_down <= 1'b0;
        wr(A_MODE, cfg(3'h4, 1'b1, 1'b0, 2'h0));
        wr(A_CMP, 32'h0000_0009);
        rd(A_CMP, 32'h0000_0009);
        wr(A_MODE, cfg(3'h1, 1'b1, 1'b0, 2'h0));
        counter_value <= 16'h0009;
        cyc(2);
        lvl(1'b0);
        counter_value <= 16'h0008;
        update_event_in <= 1'b1;
        @(posedge clk_sys);
        update_event_in <= 1'b0;
        counter_value <= 16'h0009;
        cyc(2);
        lvl(1'b1);
        wr(8'h08, 32'h0000_0001);
        #1 chk("counter_reinit", 32'h1, {31'h0, counter_reinit});
        counter_value <= 16'h0003;
        wr(A_MODE, cfg(3'h5, 1'b1, 1'b0, 2'h0));
        cyc(2);
        wr(A_MODE, cfg(3'h6, 1'b1, 1'b1, 2'h0));
        cyc(2);
        trigger_in <= 1'b1;
        cyc(3);
        lvl(1'b0);
        @(posedge clk_sys);
        trigger_in <= 1'b0;
        wr(A_MODE, cfg(3'h4, 1'b1, 1'b1, 2'h0));
        wr(A_MODE, cfg(3'h1, 1'b1, 1'b1, 2'h0));
        cyc(2);
        trigger_in <= 1'b1;
        cyc(3);
        lvl(1'b0);
        @(posedge clk_sys);
        trigger_in <= 1'b0;
        wr(A_MODE, cfg(3'h6, 1'b1, 1'b0, 2'h0));
        cyc(2);
        trigger_in <= 1'b1;
        cyc(3);
        lvl(1'b1);
        wr(A_MODE, cfg(3'h5, 1'b0, 1'b0, 2'h0));
        wr(A_MODE, cfg(3'h4, 1'b0, 1'b0, 2'h1));
        cyc(2);
        lvl(1'b1);
        wr(A_CTL, 32'h0000_0003);
        cyc(2);
        rd(8'h10, 32'h0000_0001);
        chk("single_pulse_flag", 32'h1, {31'h0, single_pulse_flag});
        final_report;
    end
endmodule
`default_nettype wire

// *** tb/occm_monitor.sv ***
/* Checker for the channel 2 output-compare block.
   Assumes binding to occm_channel and occm_consts.vh on the include path. */
`timescale 1ns/10ps
`default_nettype none
`include "occm_consts.vh"
module occm_monitor (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        counter_reinit,
    input wire logic        single_pulse_flag,
    input wire logic        ch2_reference_level,
    input wire logic        ch2_output_pin
);
    logic [2:0] mode_q;
    logic [1:0] dir_q;
    logic       pol_q;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // ----------------------------------------
    // Shadow of mode and polarity settings
    // ----------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= 3'h0;
            dir_q  <= 2'h0;
            pol_q  <= 1'b0;
        end else if (reg_write && reg_addr == `OCCM_OFS_MODE_CFG) begin
            mode_q <= reg_wdata[14:12];
            dir_q  <= reg_wdata[9:8];
        end else if (reg_write && reg_addr == `OCCM_OFS_CONTROL) begin
            pol_q  <= reg_wdata[0];
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside read slot");
    a_reinit_pulse: assert property (counter_reinit == $past(reg_write && reg_addr == 8'h08 && reg_wdata[0]))
        else $error("counter reinit pulse wrong");
    a_pulse_flag: assert property (reg_write && reg_addr == 8'h0C |=> single_pulse_flag == $past(reg_wdata[1]))
        else $error("single pulse flag wrong");
    a_pin_polarity: assert property (ch2_output_pin == (ch2_reference_level ^ $past(pol_q)))
        else $error("pin not reference xor polarity");
    a_force_high: assert property (mode_q == 3'h5 && dir_q == 2'h0 |=> ch2_reference_level)
        else $error("forced high lost");
    a_force_low: assert property (mode_q == 3'h4 && dir_q == 2'h0 |=> !ch2_reference_level)
        else $error("forced low lost");
    a_frozen_hold: assert property (mode_q == 3'h0 || dir_q != 2'h0 |=> $stable(ch2_reference_level))
        else $error("reference moved while frozen");
    a_set_hold: assert property (mode_q == 3'h1 && dir_q == 2'h0 && ch2_reference_level |=> ch2_reference_level)
        else $error("reference fell in set mode");
    a_clear_hold: assert property (mode_q == 3'h2 && dir_q == 2'h0 && !ch2_reference_level |=> !ch2_reference_level)
        else $error("reference rose in clear mode");
    c_reinit: cover property (counter_reinit);
    c_set_rise: cover property (mode_q == 3'h1 && $rose(ch2_reference_level));
    c_pwm_fall: cover property (mode_q == 3'h6 && $fell(ch2_reference_level));
endmodule
bind occm_channel occm_monitor occm_monitor_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .counter_reinit(counter_reinit), .single_pulse_flag(single_pulse_flag),
    .ch2_reference_level(ch2_reference_level), .ch2_output_pin(ch2_output_pin));
`default_nettype wire

// *** verilog/occm_channel.v ***
/*
 * Channel 2 output-compare block: mode register, buffered compare
 * value, update generation, fast trigger path and output pin.
 * Assumes counter, direction, trigger and external update inputs are
 * synchronous to clk_sys; the counter lives outside this block.
 */
// Strobed register access and the register offsets are this design's own decisions.
// Operation
// - Mode field acts only with direction zero
// - Reference active high; pin uses polarity
// - Frozen mode ignores compare matches
// - Code 001 sets reference on match
// - Code 010 clears reference on match
// - Code 011 toggles reference on match
// - Code 101 forces reference active
// - PWM1 active below compare counting up
// - PWM2 down active above compare value
// - PWM level changes on result change
// - Unbuffered writes reach shadow immediately
// - Buffered writes load shadow on update
// - Without fast enable, trigger ignored here
// - Fast trigger forces compare level quickly
// - Fast enable acts only in PWM
// - Update generate reinitialises counter, updates
`timescale 1ns/10ps
`default_nettype none
`include "occm_consts.vh"

module occm_channel #(
    parameter CNT_W = 16
) (
    input  wire                     clk_sys,
    input  wire                     rst_n,
    input  wire [`OCCM_ADDR_W-1:0]  reg_addr,
    input  wire [31:0]              reg_wdata,
    input  wire                     reg_write,
    input  wire                     reg_read,
    output reg  [31:0]              reg_rdata,
    input  wire [CNT_W-1:0]         counter_value,
    input  wire                     count_down,
    input  wire                     trigger_in,
    input  wire                     update_event_in,
    output reg                      counter_reinit,
    output reg                      single_pulse_flag,
    output reg                      ch2_reference_level,
    output reg                      ch2_output_pin
);

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg  [2:0]       ch2_compare_mode;
    reg              ch2_buffer_enable;
    reg              ch2_fast_trigger_enable;
    reg  [1:0]       ch2_direction_select;
    reg              ch2_polarity;
    reg  [CNT_W-1:0] compare_buffer;
    reg  [CNT_W-1:0] ch2_compare_value;
    reg              match_prev;
    reg              pwm_prev;
    reg              prev_frozen;
    reg              trigger_prev;

    wire             wr_mode;
    wire             wr_cmp;
    wire             wr_evt;
    wire             wr_ctl;
    wire             update_generate;
    wire             update_event;
    wire             is_pwm;
    wire             is_output;
    wire             fast_hit;
    wire             fast_level;
    wire             gen_ref;
    wire             match_now;
    wire             pwm_now;
    reg              next_ref;
    reg  [31:0]      next_rdata;

    assign wr_mode         = reg_write && (reg_addr == `OCCM_OFS_MODE_CFG);
    assign wr_cmp          = reg_write && (reg_addr == `OCCM_OFS_COMPARE);
    assign wr_evt          = reg_write && (reg_addr == `OCCM_OFS_EVENT_GEN);
    assign wr_ctl          = reg_write && (reg_addr == `OCCM_OFS_CONTROL);
    assign update_generate = wr_evt && reg_wdata[`OCCM_UG_BIT];
    assign update_event    = update_generate | update_event_in;
    assign is_pwm          = (ch2_compare_mode == `OCCM_M_PWM1) || (ch2_compare_mode == `OCCM_M_PWM2);
    assign is_output       = (ch2_direction_select == `OCCM_DIR_OUTPUT);
    assign fast_hit        = ch2_fast_trigger_enable && is_pwm && trigger_in && !trigger_prev;
    assign fast_level      = ch2_compare_mode[0] ^ count_down;

    // ------------------------------------------------------------------
    // Reference generation
    // ------------------------------------------------------------------
    occm_ref_gen #(
        .CNT_W       (CNT_W)
    ) u_ref_gen (
        .mode          (ch2_compare_mode),
        .counter_value (counter_value),
        .compare       (ch2_compare_value),
        .count_down    (count_down),
        .cur_ref       (ch2_reference_level),
        .match_prev    (match_prev),
        .pwm_prev      (pwm_prev),
        .prev_frozen   (prev_frozen),
        .next_ref      (gen_ref),
        .match_now     (match_now),
        .pwm_now       (pwm_now)
    );

    always @* begin
        next_ref = ch2_reference_level;
        if (!is_output) begin
            next_ref = ch2_reference_level;
        end else if (fast_hit) begin
            next_ref = fast_level;
        end else begin
            next_ref = gen_ref;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ch2_reference_level <= `OCCM_RST_BIT;
            ch2_output_pin      <= `OCCM_RST_BIT;
            match_prev          <= `OCCM_RST_BIT;
            pwm_prev            <= `OCCM_RST_BIT;
            prev_frozen         <= `OCCM_RST_FROZEN;
            trigger_prev        <= `OCCM_RST_BIT;
        end else begin
            ch2_reference_level <= next_ref;
            ch2_output_pin      <= next_ref ^ ch2_polarity;
            match_prev          <= match_now;
            pwm_prev            <= pwm_now;
            prev_frozen         <= (ch2_compare_mode == `OCCM_M_FROZEN);
            trigger_prev        <= trigger_in;
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ch2_compare_mode        <= `OCCM_RST_MODE;
            ch2_buffer_enable       <= `OCCM_RST_BIT;
            ch2_fast_trigger_enable <= `OCCM_RST_BIT;
            ch2_direction_select    <= `OCCM_RST_DIR;
            ch2_polarity            <= `OCCM_RST_BIT;
            single_pulse_flag       <= `OCCM_RST_BIT;
            counter_reinit          <= `OCCM_RST_BIT;
        end else begin
            counter_reinit <= update_generate;
            if (wr_mode) begin
                ch2_compare_mode        <= reg_wdata[`OCCM_MODE_HI:`OCCM_MODE_LO];
                ch2_buffer_enable       <= reg_wdata[`OCCM_BUF_EN_BIT];
                ch2_fast_trigger_enable <= reg_wdata[`OCCM_FAST_EN_BIT];
                ch2_direction_select    <= reg_wdata[`OCCM_DIR_HI:`OCCM_DIR_LO];
            end
            if (wr_ctl) begin
                ch2_polarity      <= reg_wdata[`OCCM_POL_BIT];
                single_pulse_flag <= reg_wdata[`OCCM_OPM_BIT];
            end
        end
    end

    // ------------------------------------------------------------------
    // Compare buffer and shadow
    // ------------------------------------------------------------------
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            compare_buffer    <= {CNT_W{1'b0}};
            ch2_compare_value <= {CNT_W{1'b0}};
        end else begin
            if (wr_cmp) begin
                compare_buffer <= reg_wdata[CNT_W-1:0];
            end
            if (wr_cmp && !ch2_buffer_enable) begin
                ch2_compare_value <= reg_wdata[CNT_W-1:0];
            end else if (update_event && ch2_buffer_enable) begin
                ch2_compare_value <= compare_buffer;
            end
        end
    end

    // ------------------------------------------------------------------
    // Register reads
    // ------------------------------------------------------------------
    always @* begin
        next_rdata = 32'h00000000;
        if (reg_addr == `OCCM_OFS_MODE_CFG) begin
            next_rdata[`OCCM_MODE_HI:`OCCM_MODE_LO] = ch2_compare_mode;
            next_rdata[`OCCM_BUF_EN_BIT]            = ch2_buffer_enable;
            next_rdata[`OCCM_FAST_EN_BIT]           = ch2_fast_trigger_enable;
            next_rdata[`OCCM_DIR_HI:`OCCM_DIR_LO]   = ch2_direction_select;
        end else if (reg_addr == `OCCM_OFS_COMPARE) begin
            next_rdata[CNT_W-1:0] = ch2_buffer_enable ? compare_buffer : ch2_compare_value;
        end else if (reg_addr == `OCCM_OFS_CONTROL) begin
            next_rdata[`OCCM_POL_BIT] = ch2_polarity;
            next_rdata[`OCCM_OPM_BIT] = single_pulse_flag;
        end else if (reg_addr == `OCCM_OFS_STATUS) begin
            next_rdata[`OCCM_ST_REF_BIT] = ch2_reference_level;
            next_rdata[`OCCM_ST_PIN_BIT] = ch2_output_pin;
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

endmodule

`default_nettype wire

// *** verilog/occm_consts.vh ***
/*
 * Constants of the channel 2 output-compare block: register offsets,
 * field positions, mode codes and reset values.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef OCCM_CONSTS_VH
`define OCCM_CONSTS_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OCCM_ADDR_W          8
`define OCCM_OFS_MODE_CFG    8'h00
`define OCCM_OFS_COMPARE     8'h04
`define OCCM_OFS_EVENT_GEN   8'h08
`define OCCM_OFS_CONTROL     8'h0C
`define OCCM_OFS_STATUS      8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define OCCM_MODE_HI         14
`define OCCM_MODE_LO         12
`define OCCM_BUF_EN_BIT      11
`define OCCM_FAST_EN_BIT     10
`define OCCM_DIR_HI          9
`define OCCM_DIR_LO          8
`define OCCM_UG_BIT          0
`define OCCM_POL_BIT         0
`define OCCM_OPM_BIT         1
`define OCCM_ST_REF_BIT      0
`define OCCM_ST_PIN_BIT      1

// ----------------------------------------------------------------------
// Mode codes and reset values
// ----------------------------------------------------------------------
`define OCCM_M_FROZEN        3'h0
`define OCCM_M_SET           3'h1
`define OCCM_M_CLEAR         3'h2
`define OCCM_M_TOGGLE        3'h3
`define OCCM_M_FORCE_LOW     3'h4
`define OCCM_M_FORCE_HIGH    3'h5
`define OCCM_M_PWM1          3'h6
`define OCCM_M_PWM2          3'h7
`define OCCM_DIR_OUTPUT      2'h0
`define OCCM_RST_MODE        3'h0
`define OCCM_RST_DIR         2'h0
`define OCCM_RST_BIT         1'h0
`define OCCM_RST_FROZEN      1'h1

`endif

// *** verilog/occm_ref_gen.v ***
/*
 * Next-value logic of the channel 2 reference level.
 * Assumes the caller registers the result and keeps the previous
 * match, comparison and frozen-mode states.
 */
`timescale 1ns/10ps
`default_nettype none
`include "occm_consts.vh"

module occm_ref_gen #(
    parameter CNT_W = 16
) (
    input  wire [2:0]       mode,
    input  wire [CNT_W-1:0] counter_value,
    input  wire [CNT_W-1:0] compare,
    input  wire             count_down,
    input  wire             cur_ref,
    input  wire             match_prev,
    input  wire             pwm_prev,
    input  wire             prev_frozen,
    output reg              next_ref,
    output wire             match_now,
    output wire             pwm_now
);

    wire pwm1_level;
    wire match_rise;

    assign match_now  = (counter_value == compare);
    assign match_rise = match_now & ~match_prev;
    assign pwm1_level = count_down ? ~(counter_value > compare) : (counter_value < compare);
    assign pwm_now    = mode[0] ^ pwm1_level;

    // ------------------------------------------------------------------
    // Mode decode
    // ------------------------------------------------------------------
    always @* begin
        next_ref = cur_ref;
        case (mode)
            `OCCM_M_FROZEN: next_ref = cur_ref;
            `OCCM_M_SET: begin
                if (match_rise) next_ref = 1'b1;
            end
            `OCCM_M_CLEAR: begin
                if (match_rise) next_ref = 1'b0;
            end
            `OCCM_M_TOGGLE: begin
                if (match_rise) next_ref = ~cur_ref;
            end
            `OCCM_M_FORCE_LOW:  next_ref = 1'b0;
            `OCCM_M_FORCE_HIGH: next_ref = 1'b1;
            default: begin
                // Level moves only on a new comparison result or leaving frozen
                if ((pwm_now != pwm_prev) || prev_frozen) next_ref = pwm_now;
            end
        endcase
    end

endmodule

`default_nettype wire
